/* rtl/xcr_regs.vh */
// constants for the error-control, header-log, serial-number and
// host controller capability register bank
// assumes byte offsets, dword aligned accesses on both access ports
`ifndef XCR_REGS_VH
`define XCR_REGS_VH

// extended configuration space offsets
`define XCR_OFF_ERR_CTL 12'h118
`define XCR_OFF_HDR_LOG0 12'h11c
`define XCR_OFF_HDR_LOG1 12'h120
`define XCR_OFF_HDR_LOG2 12'h124
`define XCR_OFF_HDR_LOG3 12'h128
`define XCR_OFF_SER_CAP 12'h150
`define XCR_OFF_SER_LOW 12'h154
`define XCR_OFF_SER_HIGH 12'h158

// error control fields
`define XCR_ERR_CTL_RESET 32'h0000_0050
`define XCR_BIT_CHECK_ON 8
`define XCR_BIT_CHECK_ABILITY 7
`define XCR_BIT_GENERATE_ON 6
`define XCR_BIT_GENERATE_ABILITY 5
`define XCR_FIRST_ERR_MSB 4

// serial number capability
`define XCR_SER_CAP_ID 16'h0003
`define XCR_SER_NEXT_PTR 12'h000
`define XCR_SER_VERSION 4'h1
`define XCR_SER_ZERO_BYTE 8'h00

// memory space layout, offsets within the base address window
`define XCR_MEM_WIN_BITS 16
`define XCR_CAP_LAST 16'h001f
`define XCR_OP_FIRST 16'h0020
`define XCR_OP_LAST 16'h049f
`define XCR_RT_FIRST 16'h04a0
`define XCR_RT_LAST 16'h05bf
`define XCR_DB_FIRST 16'h05c0
`define XCR_DB_LAST 16'h06c3
`define XCR_XC_FIRST 16'h09c0
`define XCR_XC_LAST 16'h09eb

// region codes
`define XCR_RGN_CAP 3'h0
`define XCR_RGN_OP 3'h1
`define XCR_RGN_RT 3'h2
`define XCR_RGN_DB 3'h3
`define XCR_RGN_XC 3'h4
`define XCR_RGN_RESERVED_BITS 3'h5

// capability register offsets and values
`define XCR_OFF_CAPLEN_VER 16'h0000
`define XCR_OFF_STRUCT1 16'h0004
`define XCR_OFF_STRUCT2 16'h0008
`define XCR_OFF_STRUCT3 16'h000c
`define XCR_OFF_CAP_PARAMS 16'h0010
`define XCR_OFF_DB_OFFSET 16'h0014
`define XCR_OFF_RT_OFFSET 16'h0018
`define XCR_CAP_LENGTH 16'h0020
`define XCR_IF_VERSION 16'h0096
`define XCR_STRUCT1 32'h0800_0840
`define XCR_STRUCT2 32'h0c00_00f1
`define XCR_STRUCT3 32'h07ff_00a0

`endif

/* rtl/xcr_bank.v */
// register bank: advanced error control, header log, serial number
// capability in extended configuration space, plus the host controller
// memory window decode and its capability registers.
// assumes the config and memory request ports come from core logic on
// i_clk; the pcie and global reset pins are asynchronous to i_clk.
`timescale 1ns/1ps
`include "xcr_regs.vh"

module xcr_bank #(
  // company identifier placed in serial bits 63:40, value arbitrary
  parameter [23:0] COMPANY_ID = 24'h5a_a5_3c,
  // capability parameters word, value arbitrary
  parameter [31:0] CAP_PARAMS = 32'h0000_0000
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_pcie_reset_n,
  input wire i_global_reset_in,
  // extended configuration space access
  input wire [11:0] i_cfg_addr,
  input wire i_cfg_rd,
  input wire i_cfg_wr,
  input wire [3:0] i_cfg_be,
  input wire [31:0] i_cfg_wdata,
  output reg o_cfg_ack,
  output reg o_cfg_hit,
  output reg [31:0] o_cfg_rdata,
  // memory space access
  input wire [63:0] i_bar_base,
  input wire [63:0] i_mem_addr,
  input wire i_mem_rd,
  input wire i_mem_wr,
  input wire [3:0] i_mem_be,
  input wire [31:0] i_mem_wdata,
  output reg o_mem_ack,
  output reg o_mem_fwd,
  output reg [2:0] o_mem_region,
  output reg [15:0] o_mem_offset,
  output reg [31:0] o_mem_rdata,
  // error reporting from the transaction layer
  input wire i_err_valid,
  input wire [4:0] i_err_index,
  input wire i_err_pending,
  input wire [127:0] i_err_header,
  // per-device unique serial low dword
  input wire [31:0] i_unit_serial_low,
  // enables steering the crc logic
  output wire o_crc_check_on,
  output wire o_crc_generate_on
);

  // byte swap: wire-order dword (earliest byte in msbs) to log order
  function [31:0] log_order;
    input [31:0] wire_dw;
    begin
      log_order = {wire_dw[7:0], wire_dw[15:8], wire_dw[23:16], wire_dw[31:24]};
    end
  endfunction

  // true when off lies within [first, last]
  function in_range;
    input [15:0] off;
    input [15:0] first;
    input [15:0] last;
    begin
      in_range = (off >= first) && (off <= last);
    end
  endfunction

  // reset pins synchronised before use
  reg pcie_meta_reg;
  reg pcie_sync_reg;
  reg global_reset_in_meta_reg;
  reg global_reset_in_sync_reg;
  wire bank_clear;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pcie_meta_reg <= 1'b1;
      pcie_sync_reg <= 1'b1;
      global_reset_in_meta_reg <= 1'b1;
      global_reset_in_sync_reg <= 1'b1;
    end
    else
    begin
      pcie_meta_reg <= ~i_pcie_reset_n;
      pcie_sync_reg <= pcie_meta_reg;
      global_reset_in_meta_reg <= i_global_reset_in;
      global_reset_in_sync_reg <= global_reset_in_meta_reg;
    end
  end

  assign bank_clear = i_rst | pcie_sync_reg | global_reset_in_sync_reg;

  // error control and header log state
  reg crc_check_on_reg;
  reg crc_generate_on_reg;
  reg [4:0] first_err_reg;
  reg [31:0] hdr_log_reg [0:3];
  wire err_ctl_wr;
  wire [31:0] err_ctl_word;
  integer i;

  assign err_ctl_wr = i_cfg_wr && (i_cfg_addr == `XCR_OFF_ERR_CTL);

  always @(posedge i_clk)
  begin
    if (bank_clear)
    begin
      crc_check_on_reg <= 1'b0;
      crc_generate_on_reg <= 1'b0;
      first_err_reg <= 5'h00;
    end
    else
    begin
      // only the two enables take writes; the rest is ignored
      if (err_ctl_wr && i_cfg_be[1])
        crc_check_on_reg <= i_cfg_wdata[`XCR_BIT_CHECK_ON];
      if (err_ctl_wr && i_cfg_be[0])
        crc_generate_on_reg <= i_cfg_wdata[`XCR_BIT_GENERATE_ON];
      // pointer loads only when no earlier error is still pending
      if (i_err_valid && !i_err_pending)
        first_err_reg <= i_err_index;
    end
  end

  always @(posedge i_clk)
  begin
    if (bank_clear)
    begin
      for (i = 0; i < 4; i = i + 1)
        hdr_log_reg[i] <= 32'h0000_0000;
    end
    else if (i_err_valid)
    begin
      // every new error overwrites the log
      hdr_log_reg[0] <= log_order(i_err_header[127:96]);
      hdr_log_reg[1] <= log_order(i_err_header[95:64]);
      hdr_log_reg[2] <= log_order(i_err_header[63:32]);
      hdr_log_reg[3] <= log_order(i_err_header[31:0]);
    end
  end

  assign o_crc_check_on = crc_check_on_reg;
  assign o_crc_generate_on = crc_generate_on_reg;

  // error control read value, reserved bits 31:9 read zero
  assign err_ctl_word = {23'h000000, crc_check_on_reg, 1'b1, crc_generate_on_reg, 1'b1,
                         first_err_reg};

  // configuration read mux
  reg [31:0] cfg_rd_next;
  reg cfg_hit_next;

  always @*
  begin
    cfg_rd_next = 32'h0000_0000;
    cfg_hit_next = 1'b1;
    case (i_cfg_addr)
      `XCR_OFF_ERR_CTL: cfg_rd_next = err_ctl_word;
      `XCR_OFF_HDR_LOG0: cfg_rd_next = hdr_log_reg[0];
      `XCR_OFF_HDR_LOG1: cfg_rd_next = hdr_log_reg[1];
      `XCR_OFF_HDR_LOG2: cfg_rd_next = hdr_log_reg[2];
      `XCR_OFF_HDR_LOG3: cfg_rd_next = hdr_log_reg[3];
      `XCR_OFF_SER_CAP: cfg_rd_next = {`XCR_SER_NEXT_PTR, `XCR_SER_VERSION,
                                       `XCR_SER_CAP_ID};
      `XCR_OFF_SER_LOW: cfg_rd_next = i_unit_serial_low;
      `XCR_OFF_SER_HIGH: cfg_rd_next = {COMPANY_ID, `XCR_SER_ZERO_BYTE};
      default: cfg_hit_next = 1'b0;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_cfg_ack <= 1'b0;
      o_cfg_hit <= 1'b0;
      o_cfg_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_cfg_ack <= i_cfg_rd | i_cfg_wr;
      o_cfg_hit <= (i_cfg_rd | i_cfg_wr) & cfg_hit_next;
      o_cfg_rdata <= i_cfg_rd ? cfg_rd_next : 32'h0000_0000;
    end
  end

  // memory window decode
  wire mem_req;
  wire mem_in_win;
  wire [15:0] mem_off;
  reg [2:0] rgn_next;
  reg [31:0] cap_rd_next;

  assign mem_req = i_mem_rd | i_mem_wr;
  // window follows the programmed base address
  assign mem_in_win = (i_mem_addr[63:`XCR_MEM_WIN_BITS] == i_bar_base[63:`XCR_MEM_WIN_BITS]);
  assign mem_off = {i_mem_addr[15:2], 2'b00};

  always @*
  begin
    if (mem_off <= `XCR_CAP_LAST)
      rgn_next = `XCR_RGN_CAP;
    else if (in_range(mem_off, `XCR_OP_FIRST, `XCR_OP_LAST))
      rgn_next = `XCR_RGN_OP;
    else if (in_range(mem_off, `XCR_RT_FIRST, `XCR_RT_LAST))
      rgn_next = `XCR_RGN_RT;
    else if (in_range(mem_off, `XCR_DB_FIRST, `XCR_DB_LAST))
      rgn_next = `XCR_RGN_DB;
    else if (in_range(mem_off, `XCR_XC_FIRST, `XCR_XC_LAST))
      rgn_next = `XCR_RGN_XC;
    else
      rgn_next = `XCR_RGN_RESERVED_BITS;
  end

  // capability registers are constants; writes land nowhere
  always @*
  begin
    case (mem_off)
      `XCR_OFF_CAPLEN_VER: cap_rd_next = {`XCR_IF_VERSION, `XCR_CAP_LENGTH};
      `XCR_OFF_STRUCT1: cap_rd_next = `XCR_STRUCT1;
      `XCR_OFF_STRUCT2: cap_rd_next = `XCR_STRUCT2;
      `XCR_OFF_STRUCT3: cap_rd_next = `XCR_STRUCT3;
      `XCR_OFF_CAP_PARAMS: cap_rd_next = CAP_PARAMS;
      `XCR_OFF_DB_OFFSET: cap_rd_next = {16'h0000, `XCR_DB_FIRST};
      `XCR_OFF_RT_OFFSET: cap_rd_next = {16'h0000, `XCR_RT_FIRST};
      default: cap_rd_next = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_mem_ack <= 1'b0;
      o_mem_fwd <= 1'b0;
      o_mem_region <= `XCR_RGN_RESERVED_BITS;
      o_mem_offset <= 16'h0000;
      o_mem_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_mem_region <= rgn_next;
      o_mem_offset <= mem_off;
      // capability and reserved space answered here, others forwarded
      o_mem_ack <= mem_req && mem_in_win &&
                   (rgn_next == `XCR_RGN_CAP || rgn_next == `XCR_RGN_RESERVED_BITS);
      o_mem_fwd <= mem_req && mem_in_win &&
                   !(rgn_next == `XCR_RGN_CAP || rgn_next == `XCR_RGN_RESERVED_BITS);
      if (i_mem_rd && mem_in_win && rgn_next == `XCR_RGN_CAP)
        o_mem_rdata <= cap_rd_next;
      else
        o_mem_rdata <= 32'h0000_0000;
    end
  end

endmodule // xcr_bank

/* test/xcr_bank_chk.sv */
// port checker for the error control, serial and capability register bank
// assumes it is bound into xcr_bank, one clock i_clk, sync reset i_rst
`timescale 1ns/1ps
module xcr_chk (
  input wire i_clk,
  input wire i_rst,
  input wire i_pcie_reset_n,
  input wire [11:0] i_cfg_addr,
  input wire i_cfg_rd,
  input wire o_cfg_hit,
  input wire [31:0] o_cfg_rdata,
  input wire [63:0] i_bar_base,
  input wire [63:0] i_mem_addr,
  input wire i_mem_rd,
  input wire o_mem_ack,
  input wire o_mem_fwd,
  input wire [2:0] o_mem_region,
  input wire [31:0] o_mem_rdata,
  input wire [31:0] i_unit_serial_low,
  input wire o_crc_check_on
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire win = i_mem_rd && i_mem_addr[63:16] == i_bar_base[63:16];
  wire [15:0] mo = {i_mem_addr[15:2], 2'b00};
  property p_ctl;
    i_cfg_rd && i_cfg_addr == 12'h118 |=> o_cfg_hit && o_cfg_rdata[31:9] == 23'h0
      && o_cfg_rdata[7] && o_cfg_rdata[5];
  endproperty
  a_ctl: assert property (p_ctl) else $error("error control fixed bits wrong");
  property p_sid;
    i_cfg_rd && i_cfg_addr == 12'h150 |=> o_cfg_rdata == 32'h0001_0003;
  endproperty
  a_sid: assert property (p_sid) else $error("serial capability header wrong");
  property p_slo;
    i_cfg_rd && i_cfg_addr == 12'h154 |=> o_cfg_rdata == $past(i_unit_serial_low);
  endproperty
  a_slo: assert property (p_slo) else $error("serial low dword wrong");
  property p_cap;
    win && mo == 16'h0 |=> o_mem_ack && o_mem_rdata == 32'h0096_0020;
  endproperty
  a_cap: assert property (p_cap) else $error("length or version wrong");
  property p_st1;
    win && mo == 16'h4 |=> o_mem_ack && o_mem_rdata == 32'h0800_0840;
  endproperty
  a_st1: assert property (p_st1) else $error("structural word one wrong");
  property p_op;
    win && mo >= 16'h0020 && mo <= 16'h049f |=> o_mem_fwd && !o_mem_ack && o_mem_region == 3'h1;
  endproperty
  a_op: assert property (p_op) else $error("operational range misdecoded");
  property p_rsv;
    win && mo >= 16'h06c4 && mo <= 16'h09bf |=> o_mem_ack && o_mem_region == 3'h5
      && o_mem_rdata == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved range misdecoded");
  property p_win;
    i_mem_rd && i_mem_addr[63:16] != i_bar_base[63:16] |=> !o_mem_ack && !o_mem_fwd;
  endproperty
  a_win: assert property (p_win) else $error("answer outside base window");
  property p_rst;
    !i_pcie_reset_n [*3] |=> !o_crc_check_on;
  endproperty
  a_rst: assert property (p_rst) else $error("check enable survives reset pin");
  c_err: cover property (o_cfg_hit && o_cfg_rdata[4:0] != 5'h0);
  c_fwd: cover property (o_mem_fwd && o_mem_region == 3'h4);
  c_on: cover property (o_crc_check_on);
endmodule // xcr_chk
bind xcr_bank xcr_chk u_chk (.*);

/* test/xcr_err_src.sv */
// model of the transaction layer that reports detected errors to the bank
// assumes the bench raises i_fire for exactly one clock per error
`timescale 1ns/1ps
module xcr_err_src (
  input wire i_fire,
  input wire [4:0] i_index,
  input wire [127:0] i_hdr,
  output wire o_err_valid,
  output wire [4:0] o_err_index,
  output wire [127:0] o_err_header
);
  // earliest byte in the top bits; between reports the bus carries junk
  assign o_err_valid = i_fire;
  assign o_err_index = i_fire ? i_index : ~i_index;
  assign o_err_header = i_fire ? i_hdr : ~i_hdr;
endmodule // xcr_err_src

/* test/tb_pcie_ext_cap_xhci_cap_regs.sv */
// self-checking bench for the register bank
// assumes xcr_bank with its checker bound in and the error source model
`timescale 1ns/1ps
module tb_pcie_ext_cap_xhci_cap_regs;
  localparam [23:0] CID = 24'h13579b; // arbitrary company identifier
  localparam [31:0] SER = 32'h2468_ace1;
  localparam [63:0] B = 64'h0000_00fe_dc12_0000;
  reg i_clk = 0, i_rst = 1, i_pcie_reset_n = 1, i_global_reset_in = 0, i_err_pending = 0;
  reg i_cfg_rd = 0, i_cfg_wr = 0, i_mem_rd = 0, i_mem_wr = 0, fire = 0;
  reg [11:0] i_cfg_addr = 0;
  reg [3:0] i_cfg_be = 0;
  reg [31:0] i_cfg_wdata = 0, q, w;
  reg [63:0] i_bar_base = B, i_mem_addr = 0;
  reg [4:0] idx = 0;
  reg [127:0] hdr = 0;
  wire o_cfg_ack, o_cfg_hit, o_mem_ack, o_mem_fwd, o_crc_check_on, o_crc_generate_on, ev;
  wire [31:0] o_cfg_rdata, o_mem_rdata;
  wire [2:0] o_mem_region;
  wire [15:0] o_mem_offset;
  wire [4:0] ei;
  wire [127:0] eh;
  integer mismatches = 0, check_count = 0, k;
  xcr_err_src src (.i_fire(fire), .i_index(idx), .i_hdr(hdr), .o_err_valid(ev),
    .o_err_index(ei), .o_err_header(eh));
  xcr_bank #(.COMPANY_ID(CID)) dut (.*, .i_mem_be(4'hf), .i_mem_wdata(32'hffff_ffff),
    .i_err_valid(ev), .i_err_index(ei), .i_err_header(eh), .i_unit_serial_low(SER));
  initial forever #12.5 i_clk = ~i_clk;
  task conclude;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cfg(input wr, input [11:0] a, input [31:0] d);
    @(posedge i_clk);
    i_cfg_rd <= !wr;
    i_cfg_wr <= wr;
    i_cfg_addr <= a;
    i_cfg_be <= 4'hf;
    i_cfg_wdata <= d;
    @(posedge i_clk);
    i_cfg_rd <= 0;
    i_cfg_wr <= 0;
    #1;
    chk({o_cfg_ack, o_cfg_hit}, {1'b1, a != 12'h110});
    q = o_cfg_rdata;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    cfg(0, a, 0);
    chk(q, e);
  endtask
  task mem(input [63:0] a, input wr, input [4:0] e, input [31:0] d);
    @(posedge i_clk);
    i_mem_rd <= !wr;
    i_mem_wr <= wr;
    i_mem_addr <= a;
    @(posedge i_clk);
    i_mem_rd <= 0;
    i_mem_wr <= 0;
    #1;
    chk({o_mem_ack, o_mem_fwd}, e[4:3]);
    chk(o_mem_offset, {a[15:2], 2'b00});
    if (e[4:3] != 2'b00)
      chk(o_mem_region, e[2:0]);
    if (e[4] && !wr)
      chk(o_mem_rdata, d);
  endtask
  task err(input [4:0] i, input [127:0] h, input p);
    @(posedge i_clk);
    idx <= i;
    hdr <= h;
    i_err_pending <= p;
    fire <= 1;
    @(posedge i_clk);
    fire <= 0;
    for (k = 0; k < 4; k = k + 1)
    begin
      w = h[127 - 32 * k -: 32];
      rd(12'h11c + 4 * k, {w[7:0], w[15:8], w[23:16], w[31:24]});
    end
  endtask
  task t_reset;
    rd(12'h118, 32'ha0);
    rd(12'h128, 32'h0);
    rd(12'h110, 32'h0);
  endtask
  task t_ctl;
    cfg(1, 12'h118, 32'hffff_ffff);
    rd(12'h118, 32'h1e0);
    chk({o_crc_check_on, o_crc_generate_on}, 2'b11);
    cfg(1, 12'h118, 32'h40);
    rd(12'h118, 32'he0);
    chk({o_crc_check_on, o_crc_generate_on}, 2'b01);
  endtask
  task t_err;
    err(5'h0c, 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff, 0);
    rd(12'h118, 32'hec);
    err(5'h03, 128'hf0e1_d2c3_b4a5_9687_7869_5a4b_3c2d_1e0f, 1);
    rd(12'h118, 32'hec);
  endtask
  task t_pin;
    for (k = 0; k < 2; k = k + 1)
    begin
      cfg(1, 12'h118, 32'h140);
      i_pcie_reset_n <= k[0];
      i_global_reset_in <= k[0];
      repeat (4) @(posedge i_clk);
      i_pcie_reset_n <= 1;
      i_global_reset_in <= 0;
      repeat (4) @(posedge i_clk);
      rd(12'h118, 32'ha0);
      chk({o_crc_check_on, o_crc_generate_on}, 2'b00);
    end
  endtask
  task t_ser;
    rd(12'h150, 32'h0001_0003);
    rd(12'h154, SER);
    rd(12'h158, {CID, 8'h00});
  endtask
  task t_mem;
    mem(B, 0, 5'h10, 32'h0096_0020);
    mem(B + 4, 1, 5'h10, 0);
    mem(B + 4, 0, 5'h10, 32'h0800_0840);
    mem(B + 64'h1c, 0, 5'h10, 0);
    mem(B + 64'h8, 0, 5'h10, 32'h0c00_00f1);
    mem(B + 64'hc, 0, 5'h10, 32'h07ff_00a0);
    mem(B + 64'h14, 0, 5'h10, 32'h0000_05c0);
    mem(B + 64'h18, 0, 5'h10, 32'h0000_04a0);
    mem(B + 64'h20, 0, 5'h09, 0);
    mem(B + 64'h49c, 0, 5'h09, 0);
    mem(B + 64'h4a0, 0, 5'h0a, 0);
    mem(B + 64'h5c0, 0, 5'h0b, 0);
    mem(B + 64'h6c4, 0, 5'h15, 0);
    mem(B + 64'h9c0, 0, 5'h0c, 0);
    mem(B + 64'h9ec, 0, 5'h15, 0);
    mem(B + 64'h1_0000, 0, 5'h00, 0);
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst <= 0;
    repeat (4) @(posedge i_clk);
    t_reset;
    t_ctl;
    t_err;
    t_pin;
    t_ser;
    t_mem;
    conclude;
  end
  initial
  begin
    #2000000;
    mismatches = mismatches + 1;
    conclude;
  end
endmodule // tb_pcie_ext_cap_xhci_cap_regs
